/* design/imem_pkg.sv */
// Constants for the internal memory access unit.
// Assumes a single core clock domain and word-addressed block storage.
package imem_pkg;

  // ---------------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] IOREG_LO     = 32'h0000_0000;
  localparam logic [31:0] IOREG_HI     = 32'h0003_ffff;
  localparam logic [31:0] L64_B0_ROM   = 32'h0004_0000;
  localparam logic [31:0] L64_B0_RAM   = 32'h0004_c000;
  localparam logic [31:0] L64_B1_ROM   = 32'h0005_0000;
  localparam logic [31:0] L64_B1_RAM   = 32'h0005_c000;
  localparam logic [31:0] L64_B2_RAM   = 32'h0006_0000;
  localparam logic [31:0] L64_B3_RAM   = 32'h0007_0000;
  localparam logic [31:0] N32_B0_ROM   = 32'h0008_0000;
  localparam logic [31:0] N32_B0_RAM   = 32'h0009_8000;
  localparam logic [31:0] N32_B1_ROM   = 32'h000a_0000;
  localparam logic [31:0] N32_B1_RAM   = 32'h000b_8000;
  localparam logic [31:0] N32_B2_RAM   = 32'h000c_0000;
  localparam logic [31:0] N32_B3_RAM   = 32'h000e_0000;
  localparam logic [31:0] S16_B0_ROM   = 32'h0010_0000;
  localparam logic [31:0] S16_B0_RAM   = 32'h0013_0000;
  localparam logic [31:0] S16_B1_ROM   = 32'h0014_0000;
  localparam logic [31:0] S16_B1_RAM   = 32'h0017_0000;
  localparam logic [31:0] S16_B2_RAM   = 32'h0018_0000;
  localparam logic [31:0] S16_B3_RAM   = 32'h001c_0000;
  localparam logic [31:0] S16_TOP      = 32'h001f_ffff;
  // Span sizes in 32-bit words of each region (normal-word view).
  localparam logic [31:0] SPAN_ROM     = 32'h0001_0000;
  localparam logic [31:0] SPAN_B01RAM  = 32'h0000_8000;
  localparam logic [31:0] SPAN_B23RAM  = 32'h0000_4000;

  // ---------------------------------------------------------------------------
  // Storage model sizes
  // ---------------------------------------------------------------------------
  localparam int          STORE_AW     = 6;
  localparam int          STORE_DEPTH  = 64;
  localparam int          NUM_BLOCKS   = 4;
  localparam int          NUM_BUF      = 32;
  localparam int          NUM_DMA      = 25;
  localparam logic [63:0] ROM_FILL     = 64'ha5a5_5a5a_0f0f_f0f0;

  typedef enum logic [2:0] {
    VIEW_NONE = 3'b000,
    VIEW_IO   = 3'b001,
    VIEW_S16  = 3'b010,
    VIEW_N32  = 3'b011,
    VIEW_E48  = 3'b100,
    VIEW_L64  = 3'b101
  } view_t;

  typedef enum logic [1:0] {
    DMA_IDLE  = 2'b00,
    DMA_XFER  = 2'b01,
    DMA_CHAIN = 2'b10
  } dma_state_t;

endpackage : imem_pkg

/* design/addr_decode.sv */
// Address decoder: maps a unified address to a view, block and word index.
// Assumes a purely combinational use by the memory unit.
`timescale 1ns/10ps
module addr_decode (
  // Request address
  input  wire logic [31:0]          addr_i,
  // Decoded target
  output imem_pkg::view_t           view_o,
  output logic [1:0]                block_o,
  output logic                      rom_o,
  output logic [31:0]               word_o
);
  import imem_pkg::*;

  // ROM and block 2/3 RAM are checked as base plus span, block 0/1 RAM up to the next base; anything unmatched is unmapped.
  always_comb begin
    view_o  = VIEW_NONE;
    block_o = 2'd0;
    rom_o   = 1'b0;
    word_o  = 32'h0000_0000;
    if (addr_i <= IOREG_HI) begin
      view_o = VIEW_IO;
      word_o = addr_i - IOREG_LO;
    end else if (addr_i >= S16_B0_ROM && addr_i <= S16_TOP) begin
      view_o = VIEW_S16;
      if (addr_i < S16_B0_ROM + 2*SPAN_ROM) begin
        rom_o = 1'b1; word_o = addr_i - S16_B0_ROM;
      end else if (addr_i >= S16_B0_RAM && addr_i < S16_B1_ROM) begin
        word_o = addr_i - S16_B0_RAM;
      end else if (addr_i >= S16_B1_ROM &&
                   addr_i < S16_B1_ROM + 2*SPAN_ROM) begin
        block_o = 2'd1; rom_o = 1'b1; word_o = addr_i - S16_B1_ROM;
      end else if (addr_i >= S16_B1_RAM && addr_i < S16_B2_RAM) begin
        block_o = 2'd1; word_o = addr_i - S16_B1_RAM;
      end else if (addr_i >= S16_B2_RAM &&
                   addr_i < S16_B2_RAM + 2*SPAN_B23RAM) begin
        block_o = 2'd2; word_o = addr_i - S16_B2_RAM;
      end else if (addr_i >= S16_B3_RAM &&
                   addr_i < S16_B3_RAM + 2*SPAN_B23RAM) begin
        block_o = 2'd3; word_o = addr_i - S16_B3_RAM;
      end else begin
        view_o = VIEW_NONE;
      end
      word_o = word_o >> 1;
    end else if (addr_i >= N32_B0_ROM && addr_i < S16_B0_ROM) begin
      view_o = VIEW_N32;
      if (addr_i < N32_B0_ROM + SPAN_ROM) begin
        rom_o = 1'b1; word_o = addr_i - N32_B0_ROM;
      end else if (addr_i >= N32_B0_RAM && addr_i < N32_B1_ROM) begin
        word_o = addr_i - N32_B0_RAM;
      end else if (addr_i >= N32_B1_ROM &&
                   addr_i < N32_B1_ROM + SPAN_ROM) begin
        block_o = 2'd1; rom_o = 1'b1; word_o = addr_i - N32_B1_ROM;
      end else if (addr_i >= N32_B1_RAM && addr_i < N32_B2_RAM) begin
        block_o = 2'd1; word_o = addr_i - N32_B1_RAM;
      end else if (addr_i >= N32_B2_RAM &&
                   addr_i < N32_B2_RAM + SPAN_B23RAM) begin
        block_o = 2'd2; word_o = addr_i - N32_B2_RAM;
      end else if (addr_i >= N32_B3_RAM &&
                   addr_i < N32_B3_RAM + SPAN_B23RAM) begin
        block_o = 2'd3; word_o = addr_i - N32_B3_RAM;
      end else begin
        view_o = VIEW_NONE;
      end
    end else if (addr_i >= L64_B0_ROM && addr_i < N32_B0_ROM) begin
      view_o = VIEW_L64;
      if (addr_i < L64_B0_ROM + SPAN_ROM/2) begin
        rom_o = 1'b1; word_o = addr_i - L64_B0_ROM;
      end else if (addr_i >= L64_B0_RAM && addr_i < L64_B1_ROM) begin
        word_o = addr_i - L64_B0_RAM;
      end else if (addr_i >= L64_B1_ROM &&
                   addr_i < L64_B1_ROM + SPAN_ROM/2) begin
        block_o = 2'd1; rom_o = 1'b1; word_o = addr_i - L64_B1_ROM;
      end else if (addr_i >= L64_B1_RAM && addr_i < L64_B2_RAM) begin
        block_o = 2'd1; word_o = addr_i - L64_B1_RAM;
      end else if (addr_i >= L64_B2_RAM &&
                   addr_i < L64_B2_RAM + SPAN_B23RAM/2) begin
        block_o = 2'd2; word_o = addr_i - L64_B2_RAM;
      end else if (addr_i >= L64_B3_RAM &&
                   addr_i < L64_B3_RAM + SPAN_B23RAM/2) begin
        block_o = 2'd3; word_o = addr_i - L64_B3_RAM;
      end else begin
        view_o = VIEW_NONE;
      end
    end
  end

endmodule : addr_decode

/* design/internal_memory_access_unit.sv */
// Internal memory access unit: two core data buses, one I/O processor
// port, circular address generation, a 25-channel DMA source.
// Assumes requesters hold address and data valid for the cycle of the
// strobe; storage is a reduced flip-flop model of each block.
`timescale 1ns/10ps
module internal_memory_access_unit (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  // Data memory bus and program memory bus
  input  wire logic [1:0]          bus_req_i,
  input  wire logic [1:0]          bus_we_i,
  input  wire logic [1:0][31:0]    bus_addr_i,
  input  wire logic [1:0][63:0]    bus_wdata_i,
  output logic      [1:0][63:0]    bus_rdata_o,
  output logic      [1:0]          bus_err_o,
  // Address generator control
  input  wire logic [1:0]          agen_use_i,
  input  wire logic [1:0][4:0]     agen_set_i,
  input  wire logic [1:0][31:0]    agen_mod_i,
  input  wire logic                agen_load_i,
  input  wire logic [4:0]          agen_load_set_i,
  input  wire logic [31:0]         agen_load_base_i,
  input  wire logic [31:0]         agen_load_len_i,
  // I/O processor port
  input  wire logic                io_req_i,
  input  wire logic                io_we_i,
  input  wire logic [31:0]         io_addr_i,
  input  wire logic [63:0]         io_wdata_i,
  output logic      [63:0]         io_rdata_o,
  output logic                     io_err_o,
  output logic                     io_reg_sel_o,
  // DMA channel requests
  input  wire logic [24:0]         dma_req_i,
  input  wire logic [31:0]         dma_addr_i,
  input  wire logic [15:0]         dma_count_i,
  input  wire logic                dma_chain_i,
  output logic                     dma_irq_o,
  output logic [4:0]               dma_chan_o,
  // Float format conversion
  input  wire logic [31:0]         fp32_i,
  input  wire logic [15:0]         fp16_i,
  output logic      [15:0]         fp16_o,
  output logic      [31:0]         fp32_o
);
  import imem_pkg::*;

  // ---------------------------------------------------------------------------
  // Circular buffer address generators
  // ---------------------------------------------------------------------------
  logic [NUM_BUF-1:0][31:0] ptr_ff, nxt_ptr, base_ff, nxt_base,
                            len_ff, nxt_len;
  logic [1:0][31:0]         eff_addr;

  always_comb begin
    logic [31:0] p;
    p        = 32'h0;
    nxt_ptr  = ptr_ff;
    nxt_base = base_ff;
    nxt_len  = len_ff;
    for (int g = 0; g < 2; g++) begin
      eff_addr[g] = agen_use_i[g] ? ptr_ff[agen_set_i[g]] : bus_addr_i[g];
      if (bus_req_i[g] && agen_use_i[g]) begin
        // Wrap by length against an arbitrary base.
        p = ptr_ff[agen_set_i[g]] + agen_mod_i[g];
        if ($signed(agen_mod_i[g]) >= 0 &&
            p >= base_ff[agen_set_i[g]] + len_ff[agen_set_i[g]])
          p = p - len_ff[agen_set_i[g]];
        else if ($signed(agen_mod_i[g]) < 0 && p < base_ff[agen_set_i[g]])
          p = p + len_ff[agen_set_i[g]];
        nxt_ptr[agen_set_i[g]] = p;
      end
    end
    if (agen_load_i) begin
      nxt_base[agen_load_set_i] = agen_load_base_i;
      nxt_len[agen_load_set_i]  = agen_load_len_i;
      nxt_ptr[agen_load_set_i]  = agen_load_base_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_ff  <= '0;
      base_ff <= '0;
      len_ff  <= '0;
    end else begin
      ptr_ff  <= nxt_ptr;
      base_ff <= nxt_base;
      len_ff  <= nxt_len;
    end
  end

  // ---------------------------------------------------------------------------
  // Address decode for three ports
  // ---------------------------------------------------------------------------
  view_t            view   [3];
  logic [1:0]       blk    [3];
  logic             rom    [3];
  logic [31:0]      wrd    [3];
  logic [31:0]      paddr  [3];
  dma_state_t  dma_st_ff, nxt_dma_st;
  logic [4:0]  chan_ff, nxt_chan;
  logic [31:0] dma_addr_ff, nxt_dma_addr;
  logic [15:0] cnt_ff, nxt_cnt;
  logic        irq_ff, nxt_irq, dma_busy;
  logic [4:0]  pick;

  assign paddr[0] = eff_addr[0];
  assign paddr[1] = eff_addr[1];
  assign paddr[2] = dma_busy ? dma_addr_ff : io_addr_i;

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_dec
      addr_decode u_dec (
        .addr_i  (paddr[gp]),
        .view_o  (view[gp]),
        .block_o (blk[gp]),
        .rom_o   (rom[gp]),
        .word_o  (wrd[gp])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Block storage: separate write ports, core and I/O in one cycle
  // ---------------------------------------------------------------------------
  // The storage is a reduced model indexed by low word bits; words beyond
  // STORE_DEPTH alias onto low entries, so no view can overrun its block.
  logic [NUM_BLOCKS-1:0][STORE_DEPTH-1:0][63:0] mem_ff, nxt_mem;
  logic [2:0]  port_req, port_we;
  logic [2:0][63:0] port_wd;

  assign port_req = {io_req_i | dma_busy, bus_req_i};
  assign port_we  = {io_we_i & ~dma_busy, bus_we_i};
  assign port_wd  = {io_wdata_i, bus_wdata_i};

  always_comb begin
    logic [STORE_AW-1:0] ix;
    ix      = '0;
    nxt_mem = mem_ff;
    // All three ports commit in the same cycle.
    for (int k = 0; k < 3; k++) begin
      ix = wrd[k][STORE_AW-1:0];
      if (port_req[k] && port_we[k] && !rom[k] &&
          view[k] != VIEW_NONE && view[k] != VIEW_IO) begin
        unique case (view[k])
          VIEW_S16: nxt_mem[blk[k]][ix][15:0] = port_wd[k][15:0];
          VIEW_N32: nxt_mem[blk[k]][ix][31:0] = port_wd[k][31:0];
          VIEW_E48: nxt_mem[blk[k]][ix][47:0] = port_wd[k][47:0];
          VIEW_L64: nxt_mem[blk[k]][ix]       = port_wd[k];
          default:  nxt_mem[blk[k]][ix]       = nxt_mem[blk[k]][ix];
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) mem_ff <= '0;
    else         mem_ff <= nxt_mem;
  end

  function automatic logic [63:0] rd_word(input view_t v, input logic r,
                                          input logic [63:0] d);
    logic [63:0] w;
    w = r ? ROM_FILL : d;
    unique case (v)
      VIEW_S16: rd_word = {48'h0, w[15:0]};
      VIEW_N32: rd_word = {32'h0, w[31:0]};
      VIEW_E48: rd_word = {16'h0, w[47:0]};
      VIEW_L64: rd_word = w;
      default:  rd_word = 64'h0;
    endcase
  endfunction : rd_word

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_rdata_o  <= '0;
      bus_err_o    <= '0;
      io_rdata_o   <= '0;
      io_err_o     <= 1'b0;
      io_reg_sel_o <= 1'b0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        bus_rdata_o[k] <= rd_word(view[k], rom[k],
                                  mem_ff[blk[k]][wrd[k][STORE_AW-1:0]]);
        bus_err_o[k]   <= bus_req_i[k] && view[k] == VIEW_NONE;
      end
      io_rdata_o   <= rd_word(view[2], rom[2],
                              mem_ff[blk[2]][wrd[2][STORE_AW-1:0]]);
      io_err_o     <= port_req[2] && view[2] == VIEW_NONE;
      io_reg_sel_o <= port_req[2] && view[2] == VIEW_IO;
    end
  end

  // ---------------------------------------------------------------------------
  // DMA sequencer
  // ---------------------------------------------------------------------------
  // Lowest channel wins; DMA only uses the I/O port so core buses never
  // wait on it.

  always_comb begin
    pick = 5'd0;
    for (int c = NUM_DMA - 1; c >= 0; c--)
      if (dma_req_i[c]) pick = 5'(c);
  end

  assign dma_busy = (dma_st_ff == DMA_XFER);

  always_comb begin
    nxt_dma_st   = dma_st_ff;
    nxt_chan     = chan_ff;
    nxt_dma_addr = dma_addr_ff;
    nxt_cnt      = cnt_ff;
    nxt_irq      = 1'b0;
    unique case (dma_st_ff)
      DMA_IDLE: if (|dma_req_i && dma_count_i != 16'h0) begin
        nxt_dma_st   = DMA_XFER;
        nxt_chan     = pick;
        nxt_dma_addr = dma_addr_i;
        nxt_cnt      = dma_count_i;
      end
      DMA_XFER: begin
        nxt_dma_addr = dma_addr_ff + 32'h1;
        nxt_cnt      = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1) begin
          nxt_irq    = 1'b1;
          nxt_dma_st = dma_chain_i ? DMA_CHAIN : DMA_IDLE;
        end
      end
      DMA_CHAIN: begin
        // Next descriptor loads without core action.
        nxt_dma_addr = dma_addr_i;
        nxt_cnt      = dma_count_i;
        nxt_dma_st   = (dma_count_i != 16'h0) ? DMA_XFER : DMA_IDLE;
      end
      default: nxt_dma_st = DMA_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dma_st_ff   <= DMA_IDLE;
      chan_ff     <= '0;
      dma_addr_ff <= '0;
      cnt_ff      <= '0;
      irq_ff      <= 1'b0;
    end else begin
      dma_st_ff   <= nxt_dma_st;
      chan_ff     <= nxt_chan;
      dma_addr_ff <= nxt_dma_addr;
      cnt_ff      <= nxt_cnt;
      irq_ff      <= nxt_irq;
    end
  end

  assign dma_irq_o  = irq_ff;
  assign dma_chan_o = chan_ff;

  // ---------------------------------------------------------------------------
  // Half-width float conversion
  // ---------------------------------------------------------------------------
  // Truncating conversion: exponent rebiased, mantissa top bits kept.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fp16_o <= '0;
      fp32_o <= '0;
    end else begin
      fp16_o <= {fp32_i[31], fp32_i[30:23] < 8'd113 ? 5'd0 :
                 (fp32_i[30:23] > 8'd142 ? 5'h1f :
                  5'(fp32_i[30:23] - 8'd112)), fp32_i[22:13]};
      fp32_o <= {fp16_i[15], fp16_i[14:10] == 5'd0 ? 8'd0 :
                 8'({3'b000, fp16_i[14:10]} + 8'd112), fp16_i[9:0], 13'h0};
    end
  end

endmodule : internal_memory_access_unit

/* bench/imem_properties.sv */
// Concurrent checks on the memory access unit, bound to its top ports.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module imem_properties
  import imem_pkg::*;
(
  // Clock and reset
  input wire logic             clock_i,
  input wire logic             rstn_i,
  // Core bus side
  input wire logic [1:0]       bus_req_i,
  input wire logic [1:0]       bus_we_i,
  input wire logic [1:0][31:0] bus_addr_i,
  input wire logic [1:0][63:0] bus_wdata_i,
  input wire logic [1:0][63:0] bus_rdata_o,
  input wire logic [1:0]       bus_err_o,
  input wire logic [1:0]       agen_use_i,
  // I/O port, DMA and conversion
  input wire logic             io_req_i,
  input wire logic [31:0]      io_addr_i,
  input wire logic             io_err_o,
  input wire logic             io_reg_sel_o,
  input wire logic             dma_irq_o,
  input wire logic [31:0]      fp32_i,
  input wire logic [15:0]      fp16_i,
  input wire logic [15:0]      fp16_o,
  input wire logic [31:0]      fp32_o
);
  logic        plain0;
  logic        wr0;
  logic [31:0] a0;
  assign plain0 = bus_req_i[0] & ~agen_use_i[0];
  assign wr0    = plain0 & bus_we_i[0];
  assign a0     = bus_addr_i[0];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_ioreg_select: assert property (
    io_req_i && io_addr_i <= IOREG_HI |=> io_reg_sel_o && !io_err_o)
    else $error("io register hit not flagged");
  a_rom_fixed: assert property (
    plain0 && !bus_we_i[0] && a0 >= N32_B0_ROM && a0 < N32_B0_RAM - 32'h8000
    |=> bus_rdata_o[0] == {32'h0, ROM_FILL[31:0]})
    else $error("rom read returned wrong contents");
  a_high_unmapped: assert property (
    plain0 && a0 >= 32'h0020_0000 |=> bus_err_o[0])
    else $error("high address not flagged");
  a_gap_err: assert property (
    plain0 && a0 >= 32'h0009_0000 && a0 < N32_B0_RAM |=> bus_err_o[0])
    else $error("reserved gap not flagged");
  a_ram_no_err: assert property (
    plain0 && a0 >= N32_B0_RAM && a0 < N32_B0_RAM + SPAN_B01RAM
    |=> !bus_err_o[0])
    else $error("mapped ram flagged as error");
  a_ram_readback: assert property (
    plain0 && !bus_we_i[0] && a0 >= N32_B0_RAM
    && a0 < N32_B0_RAM + SPAN_B01RAM && $past(wr0) && $past(a0) == a0
    |=> bus_rdata_o[0][31:0] == $past(bus_wdata_i[0][31:0], 2))
    else $error("written word not read back");
  a_irq_single: assert property (
    dma_irq_o |=> !dma_irq_o)
    else $error("irq pulse too long");
  a_fp_narrow: assert property (
    fp32_i == 32'h3f80_0000 |=> fp16_o == 16'h3c00)
    else $error("narrowing conversion wrong");
  a_fp_widen: assert property (
    fp16_i == 16'hc100 |=> fp32_o == 32'hc020_0000)
    else $error("widening conversion wrong");

  cover property (wr0 ##1 plain0 && !bus_we_i[0]);
  cover property (dma_irq_o);
  cover property (&bus_req_i && io_req_i);
endmodule : imem_properties

bind internal_memory_access_unit imem_properties chk_u (.clock_i, .rstn_i,
  .bus_req_i, .bus_we_i, .bus_addr_i, .bus_wdata_i, .bus_rdata_o, .bus_err_o,
  .agen_use_i, .io_req_i, .io_addr_i, .io_err_o, .io_reg_sel_o, .dma_irq_o,
  .fp32_i, .fp16_i, .fp16_o, .fp32_o);

/* bench/io_requester.sv */
// Stand-in for the I/O processor: one-cycle requests on the I/O port.
// Assumes the bench raises go_i just after a clock edge.
`timescale 1ns/10ps
module io_requester (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Command from the bench
  input  wire logic        go_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [63:0] wdata_i,
  // I/O port drive
  output logic             io_req_o,
  output logic             io_we_o,
  output logic [31:0]      io_addr_o,
  output logic [63:0]      io_wdata_o
);
  logic [31:0] last_addr_ff;
  logic [63:0] last_data_ff;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_addr_ff <= '0;
      last_data_ff <= '0;
    end else if (go_i) begin
      last_addr_ff <= addr_i;
      last_data_ff <= wdata_i;
    end
  end
  // Idle address and data lines invert the last value so late sampling cannot match.
  assign io_req_o   = go_i;
  assign io_we_o    = go_i & we_i;
  assign io_addr_o  = go_i ? addr_i : ~last_addr_ff;
  assign io_wdata_o = go_i ? wdata_i : ~last_data_ff;
endmodule : io_requester

/* bench/tb_top.sv */
// Self-checking bench for the memory access unit.
// Assumes the I/O port is driven by the io_requester stand-in.
`timescale 1ns/10ps
module tb_top;
  import imem_pkg::*;
  typedef struct {logic [2:0] port; logic [63:0] v;} note_t;
  logic             clock_i, rstn_i, agen_load_i, p_go, p_we, dma_chain_i;
  logic             io_req, io_we, io_err_o, io_reg_sel_o, dma_irq_o, seen;
  logic [1:0]       bus_req_i, bus_we_i, agen_use_i, bus_err_o;
  logic [1:0][31:0] bus_addr_i, agen_mod_i;
  logic [1:0][63:0] bus_wdata_i, bus_rdata_o;
  logic [1:0][4:0]  agen_set_i;
  logic [4:0]       agen_load_set_i, dma_chan_o;
  logic [31:0]      agen_load_base_i, agen_load_len_i, io_addr, dma_addr_i;
  logic [31:0]      fp32_i, fp32_o, p_addr, seed;
  logic [63:0]      io_wdata, io_rdata_o, p_wdata, d;
  logic [63:0]      dv[4];
  logic [24:0]      dma_req_i;
  logic [15:0]      dma_count_i, fp16_i, fp16_o;
  int               n_fail, cmp_count, due, irqs;
  note_t            q[$];
  logic [31:0] ram_b[3] = '{S16_B0_RAM, N32_B0_RAM, L64_B0_RAM};
  logic [31:0] rom_b[3] = '{S16_B0_ROM, N32_B0_ROM, L64_B0_ROM};
  logic [63:0] vm[3] = '{64'hffff, 64'hffff_ffff, '1};
  logic [31:0] ioa[4] = '{32'h0, 32'h3_ffff, 32'h4_0000, 32'h20_0000};
  logic [31:0] f32[3] = '{32'h3f80_0000, 32'hc020_0000, 32'h4000_0000};
  logic [15:0] f16[3] = '{16'h3c00, 16'hc100, 16'h4000};
  string       pn[7] = '{"rd0", "rd1", "io", "err", "sel", "f16", "f32"};

  io_requester io_u (.clock_i, .rstn_i, .go_i(p_go),
    .we_i(p_we), .addr_i(p_addr), .wdata_i(p_wdata), .io_req_o(io_req),
    .io_we_o(io_we), .io_addr_o(io_addr), .io_wdata_o(io_wdata));
  internal_memory_access_unit dut_u (.clock_i, .rstn_i, .bus_req_i,
    .bus_we_i, .bus_addr_i, .bus_wdata_i, .bus_rdata_o, .bus_err_o,
    .agen_use_i, .agen_set_i, .agen_mod_i, .agen_load_i, .agen_load_set_i,
    .agen_load_base_i, .agen_load_len_i, .io_req_i(io_req), .io_we_i(io_we),
    .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_rdata_o, .io_err_o,
    .io_reg_sel_o, .dma_req_i, .dma_addr_i, .dma_count_i, .dma_chain_i,
    .dma_irq_o, .dma_chan_o, .fp32_i, .fp16_i, .fp16_o, .fp32_o);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask : step
  task automatic idle();
    bus_req_i = '0;
    bus_we_i = '0;
    agen_use_i = '0;
    agen_load_i = 1'b0;
    p_go = 1'b0;
  endtask : idle
  task automatic bus_op(input int b, input logic w, input logic [31:0] a,
                        input logic [63:0] wd);
    bus_req_i[b] = 1'b1;
    bus_we_i[b] = w;
    bus_addr_i[b] = a;
    bus_wdata_i[b] = wd;
  endtask : bus_op
  task automatic io_op(input logic w, input logic [31:0] a,
                       input logic [63:0] wd);
    p_go = 1'b1;
    p_we = w;
    p_addr = a;
    p_wdata = wd;
  endtask : io_op
  task automatic exp(input logic [2:0] p, input logic [63:0] v);
    q.push_back('{p, v});
  endtask : exp
  task automatic cmp(input string nm, input logic [63:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // Clock, watchdog and result monitor
  // ---------------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  // Every note is due one cycle after it was queued.
  initial begin
    note_t n;
    logic [63:0] s;
    due = 0;
    forever begin
      @(posedge clock_i);
      #3;
      repeat (due) begin
        n = q.pop_front();
        case (n.port)
          3'h0: s = bus_rdata_o[0];
          3'h1: s = bus_rdata_o[1];
          3'h2: s = io_rdata_o;
          3'h3: s = 64'(bus_err_o);
          3'h4: s = 64'({io_err_o, io_reg_sel_o});
          3'h5: s = 64'(fp16_o);
          default: s = 64'(fp32_o);
        endcase
        cmp(pn[n.port], n.v, s);
      end
      due = q.size();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h0001_3732;
    n_fail = 0;
    cmp_count = 0;
    rstn_i = 1'b0;
    idle();
    {bus_addr_i, bus_wdata_i, agen_set_i, agen_mod_i} = '0;
    {agen_load_set_i, agen_load_base_i, agen_load_len_i} = '0;
    {p_we, p_addr, p_wdata, dma_req_i, dma_addr_i} = '0;
    {dma_count_i, dma_chain_i, fp32_i, fp16_i} = '0;
    repeat (12) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    step();
    for (int i = 0; i < 3; i++) begin
      d = {rnd(), rnd()};
      bus_op(0, 1'b1, ram_b[i] + 32'(i + 1), d);
      step();
      bus_op(0, 1'b0, ram_b[i] + 32'(i + 1), ~d);
      exp(0, d & vm[i]);
      step();
      bus_op(0, 1'b1, rom_b[i], d);
      step();
      bus_op(0, 1'b0, rom_b[i], ~d);
      exp(0, ROM_FILL & vm[i]);
      step();
    end
    d = {rnd(), rnd()};
    bus_op(0, 1'b1, N32_B0_RAM + 32'h5, d);
    step();
    bus_op(0, 1'b1, 32'h0009_0005, ~d);
    exp(3, 64'h1);
    step();
    bus_op(0, 1'b1, 32'h0020_0000, ~d);
    bus_op(1, 1'b1, S16_TOP, ~d);
    exp(3, 64'h3);
    step();
    bus_op(0, 1'b0, N32_B0_RAM + 32'h5, 64'h0);
    exp(0, d & vm[1]);
    exp(3, 64'h2);
    step();
    d = {rnd(), rnd()};
    bus_op(0, 1'b1, N32_B2_RAM + 32'h2, d);
    bus_op(1, 1'b1, N32_B3_RAM + 32'h2, ~d);
    io_op(1'b1, N32_B2_RAM + 32'h3, d ^ 64'h0f);
    step();
    bus_op(0, 1'b0, N32_B2_RAM + 32'h2, 64'h0);
    bus_op(1, 1'b0, N32_B3_RAM + 32'h2, 64'h0);
    io_op(1'b0, N32_B2_RAM + 32'h3, 64'h0);
    exp(0, d & vm[1]);
    exp(1, ~d & vm[1]);
    exp(2, (d ^ 64'h0f) & vm[1]);
    step();
    idle();
    step();
    for (int i = 0; i < 4; i++) begin
      io_op(1'b0, ioa[i], 64'h0);
      exp(4, 64'({ioa[i] > S16_TOP, ioa[i] <= IOREG_HI}));
      step();
    end
    idle();
    step();
    // An odd base and length exercise wrap with no alignment.
    agen_load_i = 1'b1;
    agen_load_set_i = 5'h1f;
    agen_load_base_i = N32_B2_RAM + 32'h9;
    agen_load_len_i = 32'h3;
    step();
    for (int i = 0; i < 4; i++) begin
      dv[i] = {rnd(), rnd()};
      agen_load_i = 1'b0;
      agen_use_i[0] = 1'b1;
      agen_set_i[0] = 5'h1f;
      agen_mod_i[0] = 32'h1;
      bus_op(0, 1'b1, 32'h0, dv[i]);
      step();
    end
    for (int i = 0; i < 3; i++) begin
      agen_use_i[0] = 1'b0;
      bus_op(0, 1'b0, N32_B2_RAM + 32'h9 + 32'(i), 64'h0);
      exp(0, dv[(i == 0) ? 3 : i] & vm[1]);
      step();
    end
    for (int i = 0; i < 3; i++) begin
      fp32_i = f32[i];
      fp16_i = f16[i];
      exp(5, 64'(f16[i]));
      exp(6, 64'(f32[i]));
      step();
    end
    for (int ch = 0; ch < 25; ch++) begin
      dma_req_i = 25'h1 << ch;
      dma_addr_i = N32_B3_RAM + 32'(ch);
      {dma_count_i, dma_chain_i} = {16'h2, 1'(ch % 2)};
      step();
      dma_req_i = '0;
      seen = 1'b0;
      irqs = 0;
      d = {rnd(), rnd()};
      for (int k = 0; k < 12; k++) begin
        if (dma_chan_o === 5'(ch)) seen = 1'b1;
        if (dma_irq_o === 1'b1) irqs++;
        if (k < 2) bus_op(0, k == 0, N32_B1_RAM + 32'h4, d);
        if (k == 1) exp(0, d & vm[1]);
        if (k == 2) {bus_req_i, dma_chain_i} = '0;
        step();
      end
      cmp("dma_chan", 64'h1, 64'(seen));
      cmp("dma_irq", 64'(1 + ch % 2), 64'(irqs));
    end
    repeat (3) step();
    final_report();
  end
endmodule : tb_top
